// ---- supervision_regs.svh ----
// Constants of the special-setting supervision block
`ifndef SUPERVISION_REGS_SVH
`define SUPERVISION_REGS_SVH
`define OVERSPEED_MAX_RPM 16'd20000
`define OVERSPEED_INTERNAL_RPM 16'd6000
`define INIT_WAIT_MS 1500
`define WAIT_STEP_MS 100
`define WAIT_SETTING_MAX 7'd100
`define CLK_HZ 10000000
`define CYCLES_PER_MS (`CLK_HZ / 1000)
`define LATCH_EXT_BIT 0
`define LATCH_GEN_BIT 1
`define LOAD_GAIN_MIN -8'sd100
`define LOAD_GAIN_MAX 8'sd100
`define LOAD_GAIN_RST 8'sd0
`define LOAD_TC_MIN 12'd10
`define LOAD_TC_MAX 12'd2500
`define LOAD_TC_RST 12'd53
`define LATCH_SEL_RST 2'h0
`define WAIT_SET_RST 7'h00
`define THRESH_RST 16'h0000
`endif

// ---- supervision_pkg.sv ----
// Types of the special-setting supervision block
package supervision_pkg;
   typedef enum logic [1:0] {ST_INIT, ST_EXTRA, ST_READY} powerup_e;
   typedef logic signed [7:0] gain_t;
endpackage : supervision_pkg

// ---- warn_bus_if.sv ----
// Warning conditions and latch controls between top and latch module
`timescale 1ns/1ns
`default_nettype none
interface warn_bus_if;
   logic gen_cond;
   logic ext_cond;
   logic [1:0] latch_sel;
   logic clear;
   logic gen_warn;
   logic ext_warn;
   modport top (output gen_cond, ext_cond, latch_sel, clear, input gen_warn, ext_warn);
   modport latch (input gen_cond, ext_cond, latch_sel, clear, output gen_warn, ext_warn);
endinterface : warn_bus_if
`default_nettype wire

// ---- warning_latch.sv ----
// Warning indication latch
`timescale 1ns/1ns
`default_nettype none
`include "supervision_regs.svh"
module warning_latch (
   input wire logic sys_clk,
   input wire logic rstn,
   warn_bus_if.latch wb
);
   logic gen_r;
   logic gen_nxt;
   logic ext_r;
   logic ext_nxt;

   always_comb begin
      // Latched mode: condition sets, clear only drops it when condition is gone
      if (wb.latch_sel[`LATCH_EXT_BIT]) begin
         ext_nxt = wb.ext_cond | (ext_r & ~wb.clear);
      end else begin
         ext_nxt = wb.ext_cond;
      end
      if (wb.latch_sel[`LATCH_GEN_BIT]) begin
         gen_nxt = wb.gen_cond | (gen_r & ~wb.clear);
      end else begin
         gen_nxt = wb.gen_cond;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         gen_r <= 1'b0;
         ext_r <= 1'b0;
      end else begin
         gen_r <= gen_nxt;
         ext_r <= ext_nxt;
      end
   end

   assign wb.gen_warn = gen_r;
   assign wb.ext_warn = ext_r;
endmodule : warning_latch
`default_nettype wire

// ---- servo_special_supervision.sv ----
// Special-setting supervision: second over-speed, power-up wait, warnings, load compensation
`timescale 1ns/1ns
`default_nettype none
`include "supervision_regs.svh"
// What this block does
// - During the alarm emergency stop, a speed above the threshold (0..20000 r/min) raises the second over-speed fault.
// - A threshold of zero selects the internal over-speed level instead.
// - After power-up the block waits 1.5 s plus the setting (0..100) times 0.1 s before signalling ready.
// - Bit 0 of the latch select makes the extended warning latched when 1 and following when 0.
// - Bit 1 of the latch select makes the general warning latched when 1 and following when 0.
// - The load compensation gain is a signed -100..100 percent value, default 0, used in position and speed control.
// - The load compensation filter time constant is 10..2500 in 0.01 ms units, default 53.
module servo_special_supervision #(
   parameter int INIT_CYCLES = `INIT_WAIT_MS * `CYCLES_PER_MS,
   parameter int STEP_CYCLES = `WAIT_STEP_MS * `CYCLES_PER_MS,
   parameter logic [15:0] INTERNAL_RPM = `OVERSPEED_INTERNAL_RPM
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic signed [16:0] motor_speed,
   input wire logic estop_active,
   input wire logic [15:0] second_overspeed_threshold,
   input wire logic [6:0] powerup_wait_setting,
   input wire logic [1:0] warning_latch_select,
   input wire logic signed [7:0] load_comp_gain,
   input wire logic [11:0] load_comp_filter_tc,
   input wire logic gen_warn_cond,
   input wire logic ext_warn_cond,
   input wire logic warn_clear,
   output logic second_overspeed_fault,
   output logic init_done,
   output logic gen_warning,
   output logic ext_warning,
   output logic signed [7:0] load_comp_gain_eff,
   output logic [11:0] load_comp_tc_eff
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [16:0] magnitude(input logic signed [16:0] v);
      return v[16] ? 17'(-v) : 17'(v);
   endfunction : magnitude

   // Limit in force: internal level for zero, capped at the range top
   function automatic logic [15:0] overspeed_limit(input logic [15:0] th);
      logic [15:0] lv;
      if (th == 16'h0000) begin
         lv = INTERNAL_RPM;
      end else begin
         lv = th;
      end
      if (lv > `OVERSPEED_MAX_RPM) begin
         lv = `OVERSPEED_MAX_RPM;
      end
      return lv;
   endfunction : overspeed_limit

   // Gain kept inside -100..100 percent
   function automatic supervision_pkg::gain_t clamp_gain(input logic signed [7:0] v);
      supervision_pkg::gain_t r;
      r = v;
      if (v > `LOAD_GAIN_MAX) begin
         r = `LOAD_GAIN_MAX;
      end else if (v < `LOAD_GAIN_MIN) begin
         r = `LOAD_GAIN_MIN;
      end
      return r;
   endfunction : clamp_gain

   // Filter time constant kept inside 10..2500
   function automatic logic [11:0] clamp_tc(input logic [11:0] v);
      logic [11:0] r;
      r = v;
      if (v < `LOAD_TC_MIN) begin
         r = `LOAD_TC_MIN;
      end else if (v > `LOAD_TC_MAX) begin
         r = `LOAD_TC_MAX;
      end
      return r;
   endfunction : clamp_tc

   // ----------------------------------------
   // Second over-speed
   // ----------------------------------------
   logic ovs_r;
   logic ovs_nxt;
   logic [15:0] limit;

   always_comb begin
      limit = overspeed_limit(second_overspeed_threshold);
      // Fault sticks until the stop sequence ends
      ovs_nxt = ovs_r;
      if (!estop_active) begin
         ovs_nxt = 1'b0;
      // Magnitude, so reverse rotation is caught too
      end else if (magnitude(motor_speed) > {1'b0, limit}) begin
         ovs_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ovs_r <= 1'b0;
      end else begin
         ovs_r <= ovs_nxt;
      end
   end
   assign second_overspeed_fault = ovs_r;

   // ----------------------------------------
   // Power-up wait
   // ----------------------------------------
   supervision_pkg::powerup_e st_r;
   supervision_pkg::powerup_e st_nxt;
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic [6:0] steps_r;
   logic [6:0] steps_nxt;
   logic [6:0] wait_cap;
   logic [6:0] wait_lat_r;
   logic [6:0] wait_lat_nxt;

   assign wait_cap = (powerup_wait_setting > `WAIT_SETTING_MAX) ? `WAIT_SETTING_MAX : powerup_wait_setting;

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r + 32'd1;
      steps_nxt = steps_r;
      wait_lat_nxt = wait_lat_r;
      case (st_r)
         supervision_pkg::ST_INIT: begin
            if (cnt_r >= 32'(INIT_CYCLES - 1)) begin
               cnt_nxt = 32'd0;
               steps_nxt = 7'd0;
               // Setting is taken once, at the end of the fixed wait
               wait_lat_nxt = wait_cap;
               st_nxt = (wait_cap == 7'd0) ? supervision_pkg::ST_READY : supervision_pkg::ST_EXTRA;
            end
         end
         supervision_pkg::ST_EXTRA: begin
            if (cnt_r >= 32'(STEP_CYCLES - 1)) begin
               cnt_nxt = 32'd0;
               steps_nxt = steps_r + 7'd1;
               if (steps_r + 7'd1 >= wait_lat_r) begin
                  st_nxt = supervision_pkg::ST_READY;
               end
            end
         end
         supervision_pkg::ST_READY: begin
            // Counter stops once ready
            cnt_nxt = cnt_r;
         end
         default: begin
            // Unknown state restarts the wait
            st_nxt = supervision_pkg::ST_INIT;
            cnt_nxt = 32'd0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         st_r <= supervision_pkg::ST_INIT;
         cnt_r <= 32'd0;
         steps_r <= `WAIT_SET_RST;
         wait_lat_r <= `WAIT_SET_RST;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         steps_r <= steps_nxt;
         wait_lat_r <= wait_lat_nxt;
      end
   end
   assign init_done = (st_r == supervision_pkg::ST_READY);

   // ----------------------------------------
   // Warnings
   // ----------------------------------------
   // Latches kept in their own module
   warn_bus_if wb ();
   assign wb.gen_cond = gen_warn_cond;
   assign wb.ext_cond = ext_warn_cond;
   assign wb.latch_sel = warning_latch_select;
   assign wb.clear = warn_clear;

   warning_latch u_latch (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .wb(wb)
   );
   assign gen_warning = wb.gen_warn;
   assign ext_warning = wb.ext_warn;

   // ----------------------------------------
   // Load compensation settings
   // ----------------------------------------
   supervision_pkg::gain_t gain_r;
   supervision_pkg::gain_t gain_nxt;
   logic [11:0] tc_r;
   logic [11:0] tc_nxt;

   // Clamped copies, one cycle late
   always_comb begin
      gain_nxt = clamp_gain(load_comp_gain);
      tc_nxt = clamp_tc(load_comp_filter_tc);
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         gain_r <= `LOAD_GAIN_RST;
         tc_r <= `LOAD_TC_RST;
      end else begin
         gain_r <= gain_nxt;
         tc_r <= tc_nxt;
      end
   end
   assign load_comp_gain_eff = gain_r;
   assign load_comp_tc_eff = tc_r;
endmodule : servo_special_supervision
`default_nettype wire

// ---- supervision_sva.sv ----
// Port checker of the supervision block
`timescale 1ns/1ns
`default_nettype none
module supervision_sva #(
   parameter logic [15:0] INTERNAL_RPM = 16'h1770
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic signed [16:0] motor_speed,
   input wire logic estop_active,
   input wire logic [15:0] second_overspeed_threshold,
   input wire logic [1:0] warning_latch_select,
   input wire logic gen_warn_cond,
   input wire logic ext_warn_cond,
   input wire logic warn_clear,
   input wire logic second_overspeed_fault,
   input wire logic gen_warning,
   input wire logic ext_warning
);
   logic [16:0] mag;
   logic [15:0] lim;
   logic over;
   assign mag = motor_speed[16] ? -motor_speed : motor_speed;
   assign lim = second_overspeed_threshold == 16'h0000 ? INTERNAL_RPM :
      second_overspeed_threshold > 16'h4e20 ? 16'h4e20 : second_overspeed_threshold;
   assign over = estop_active && mag > {1'b0, lim};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_fault_raise: assert property (over |=> second_overspeed_fault)
      else $error("fault missing");
   a_fault_clear: assert property (!estop_active |=> !second_overspeed_fault)
      else $error("fault stays");
   a_fault_cause: assert property ($rose(second_overspeed_fault) |-> $past(over))
      else $error("fault uncaused");
   a_ext_follow: assert property (!warning_latch_select[0] |=> ext_warning == $past(ext_warn_cond))
      else $error("ext not following");
   a_ext_hold: assert property (warning_latch_select[0] && ext_warning && !warn_clear |=> ext_warning)
      else $error("ext not held");
   a_gen_follow: assert property (!warning_latch_select[1] |=> gen_warning == $past(gen_warn_cond))
      else $error("gen not following");
   a_gen_latch: assert property (warning_latch_select[1] && gen_warn_cond |=> gen_warning)
      else $error("gen not set");
   a_gen_hold: assert property (warning_latch_select[1] && gen_warning && !warn_clear |=> gen_warning)
      else $error("gen not held");
endmodule : supervision_sva
bind servo_special_supervision supervision_sva #(.INTERNAL_RPM(INTERNAL_RPM)) supervision_sva_i (.*);
`default_nettype wire

// ---- host_cfg.sv ----
// Host model that writes the drive settings
`timescale 1ns/1ns
`default_nettype none
module host_cfg (
   input wire logic sys_clk,
   output logic [15:0] second_overspeed_threshold,
   output logic [6:0] powerup_wait_setting,
   output logic [1:0] warning_latch_select,
   output logic signed [7:0] load_comp_gain,
   output logic [11:0] load_comp_filter_tc
);
   // Writes land just after a rising edge
   task automatic put(input logic [15:0] t, input logic [1:0] s, input logic [7:0] g, input logic [11:0] c);
      @(posedge sys_clk);
      second_overspeed_threshold <= t;
      warning_latch_select <= s;
      load_comp_gain <= g;
      load_comp_filter_tc <= c;
   endtask : put
   initial begin
      powerup_wait_setting = 7'h03;
      second_overspeed_threshold = 16'h0000;
      warning_latch_select = 2'h0;
      load_comp_gain = 8'sh00;
      load_comp_filter_tc = 12'h035;
   end
endmodule : host_cfg
`default_nettype wire

// ---- servo_special_supervision_bench.sv ----
// Self-checking bench of the supervision block
`timescale 1ns/1ns
`default_nettype none
`define CHK(e, s) begin n_tests++; if ((e) !== (s)) begin err_total++; $display("BAD outputs exp %h got %h", e, s); end end
module servo_special_supervision_bench;
   typedef struct {int due; logic [23:0] m; logic [23:0] v;} note_s;
   note_s q[$];
   int cyc = 0, err_total = 0, n_tests = 0;
   logic sys_clk = 0, rstn = 0, estop_active = 0, gen_warn_cond = 0, ext_warn_cond = 0, warn_clear = 0;
   logic signed [16:0] motor_speed = 0;
   logic second_overspeed_fault, init_done, gen_warning, ext_warning, es, gc, ec, cl, fm = 0, gm = 0, em = 0;
   logic [15:0] second_overspeed_threshold, t, lim;
   logic [6:0] powerup_wait_setting;
   logic [1:0] warning_latch_select, s;
   logic signed [7:0] load_comp_gain, load_comp_gain_eff, g, ge;
   logic [11:0] load_comp_filter_tc, load_comp_tc_eff, c, ce;
   logic [16:0] sp, mag;
   logic [23:0] ob;
   servo_special_supervision #(.INIT_CYCLES(20), .STEP_CYCLES(5)) servo_special_supervision_i (.*);
   host_cfg host_cfg_i (.*);
   assign ob = {second_overspeed_fault, init_done, gen_warning, ext_warning, load_comp_gain_eff, load_comp_tc_eff};
   task automatic note(input logic [23:0] m, input logic [23:0] v, input int d);
      q.push_back('{cyc + d, m, v});
   endtask : note
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      #300000;
      err_total++;
      end_sim();
   end
   always @(negedge sys_clk) begin
      cyc++;
      while (q.size() > 0 && q[0].due <= cyc) begin
         `CHK(q[0].v, ob & q[0].m)
         void'(q.pop_front());
      end
   end
   initial begin
      void'($urandom(32'h465c));
      repeat (4) @(posedge sys_clk);
      note(24'hffffff, 24'h000035, 1);
      rstn <= 1'b1;
      note(24'h400000, 24'h000000, 33);
      note(24'h400000, 24'h400000, 40);
      repeat (45) @(posedge sys_clk);
      repeat (300) begin
         t = $urandom % 8 == 0 ? 16'h0000 : 16'($urandom % 22000);
         s = 2'($urandom);
         g = 8'($urandom);
         c = 12'($urandom);
         sp = 17'($urandom % 46001 - 23000);
         es = $urandom % 4 != 0;
         gc = 1'($urandom);
         ec = 1'($urandom);
         cl = $urandom % 4 == 0;
         host_cfg_i.put(t, s, g, c);
         estop_active <= es;
         motor_speed <= sp;
         gen_warn_cond <= gc;
         ext_warn_cond <= ec;
         warn_clear <= cl;
         lim = t == 16'h0000 ? 16'h1770 : t > 16'h4e20 ? 16'h4e20 : t;
         mag = sp[16] ? -sp : sp;
         fm = es && (fm || mag > {1'b0, lim});
         gm = gc || (s[1] && gm && !cl);
         em = ec || (s[0] && em && !cl);
         ge = g > 8'sh64 ? 8'sh64 : g < -8'sh64 ? -8'sh64 : g;
         ce = c < 12'h00a ? 12'h00a : c > 12'h9c4 ? 12'h9c4 : c;
         note(24'hffffff, {fm, 1'b1, gm, em, ge, ce}, 2);
      end
      repeat (3) @(posedge sys_clk);
      end_sim();
   end
endmodule : servo_special_supervision_bench
`default_nettype wire
